// ### eqia_pkg.sv
// constants, types and rule overview for the equalizer indirect access block
// Overview of operation
// - writing file read pointer loads 16-bit file word into staging low bits and clears bits 31:16
// - file read transfer leaves the addressed file location unchanged
// - factory map: 0-7 ffe coeffs, 8-15 taps, 16-25 predictor, 26/27 gain words
// - 28-34 expose live stage signals in fixed order; 35-47 reserved
// - writing file write pointer stores staging low 16 bits into the file
// - file write uses only staging bits 15:0 and leaves staging intact
// - writing microprogram read pointer loads 32-bit store word into staging
// - writing microprogram write pointer stores all 32 staging bits, staging intact
// - four-byte host readable and writable staging word at word index 0x7c, bus bytes 0x1f0-0x1f3
// - every select-register transfer uses the single shared staging word
package eqia_pkg;
  localparam logic [7:0] EQIA_OFS_FILE_RD   = 8'h78;
  localparam logic [7:0] EQIA_OFS_FILE_WR   = 8'h79;
  localparam logic [7:0] EQIA_OFS_PROG_RD   = 8'h7a;
  localparam logic [7:0] EQIA_OFS_PROG_WR   = 8'h7b;
  localparam logic [7:0] EQIA_OFS_STAGE     = 8'h7c;
  // offsets above are word indices; the bus byte address is four times the index
  localparam int         EQIA_ADDR_W        = 10;
  localparam int         EQIA_IDX_LSB       = 2;
  localparam int         EQIA_PTR_W         = 6;
  localparam int         EQIA_FILE_W        = 16;
  localparam int         EQIA_PROG_W        = 32;
  localparam int         EQIA_FILE_DEPTH    = 48;
  localparam int         EQIA_PROG_DEPTH    = 64;
  localparam logic [5:0] EQIA_FILE_LAST     = 6'h2f;
  localparam logic [5:0] EQIA_LIVE_FIRST    = 6'h1c;
  localparam logic [5:0] EQIA_LIVE_LAST     = 6'h22;
  localparam int         EQIA_LIVE_N        = 7;
  localparam logic [1:0] EQIA_RESP_OKAY     = 2'b00;
  localparam logic [1:0] EQIA_RESP_SLVERR   = 2'b10;
  localparam logic [31:0] EQIA_STAGE_RST    = 32'h0000_0000;
  localparam logic [5:0]  EQIA_PTR_RST      = 6'h00;
  // symbol period in ns and its cycle count at 250 MHz
  localparam int         EQIA_CLK_NS        = 4;
  localparam int         EQIA_SYM_NS        = 2000;
  localparam int         EQIA_SYM_CYC       = EQIA_SYM_NS / EQIA_CLK_NS;

  typedef enum logic [3:0] {
    EQIA_OP_FILE_RD = 4'b0001,
    EQIA_OP_FILE_WR = 4'b0010,
    EQIA_OP_PROG_RD = 4'b0100,
    EQIA_OP_PROG_WR = 4'b1000
  } eqia_op_t;
endpackage : eqia_pkg

// ### eqia_file.sv
// equalizer register file with live stage signals overlaying stored words 28-34
`timescale 1ns/100ps
module eqia_file
  import eqia_pkg::*;
#(
  parameter int DEPTH = EQIA_FILE_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       wr_en,
  input  wire logic [EQIA_PTR_W-1:0]      addr,
  input  wire logic [EQIA_FILE_W-1:0]     wdata,
  input  wire logic [EQIA_LIVE_N*EQIA_FILE_W-1:0] live_in,
  output logic      [EQIA_FILE_W-1:0]     rdata
);
  logic [EQIA_FILE_W-1:0] mem [DEPTH];
  logic [EQIA_FILE_W-1:0] live_word;
  logic [2:0]             live_idx;

  always_comb begin
    live_idx  = 3'(addr - EQIA_LIVE_FIRST);
    live_word = live_in[live_idx*EQIA_FILE_W +: EQIA_FILE_W];
  end

  // contents are undefined at reset, as for any ram
  always_ff @(posedge clk) begin
    if (wr_en && addr <= EQIA_FILE_LAST) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (addr >= EQIA_LIVE_FIRST && addr <= EQIA_LIVE_LAST) begin
      rdata <= live_word;
    end else if (addr <= EQIA_FILE_LAST) begin
      rdata <= mem[addr];
    end else begin
      rdata <= '0;
    end
  end
endmodule : eqia_file

// ### eqia_prog.sv
// equalizer microprogram store
`timescale 1ns/100ps
module eqia_prog
  import eqia_pkg::*;
#(
  parameter int DEPTH = EQIA_PROG_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   wr_en,
  input  wire logic [EQIA_PTR_W-1:0]  addr,
  input  wire logic [EQIA_PROG_W-1:0] wdata,
  output logic      [EQIA_PROG_W-1:0] rdata
);
  logic [EQIA_PROG_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule : eqia_prog

// ### eqia_top.sv
// axi4-lite indirect access port to the equalizer file and microprogram store
`timescale 1ns/100ps
module eqia_top
  import eqia_pkg::*;
(
  input  wire logic                               clk,
  input  wire logic                               nrst,
  input  wire logic [EQIA_ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [EQIA_ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire logic [EQIA_LIVE_N*EQIA_FILE_W-1:0] live_in,
  output logic                                    xfer_busy
);
  typedef struct packed {
    logic                   aw_hold;
    logic [7:0]             aw_addr;
    logic                   w_hold;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [5:0]             file_rd_ptr;
    logic [5:0]             file_wr_ptr;
    logic [5:0]             prog_rd_ptr;
    logic [5:0]             prog_wr_ptr;
    logic [31:0]            stage;
    logic [3:0]             op;
    logic [1:0]             phase;
  } eqia_state_t;

  eqia_state_t s_q, s_d;

  logic                   wr_fire;
  logic                   rd_fire;
  logic                   map_ok;
  logic [31:0]            wmask;
  logic [31:0]            rd_word;
  logic [EQIA_PTR_W-1:0]  file_addr;
  logic [EQIA_PTR_W-1:0]  prog_addr;
  logic [EQIA_FILE_W-1:0] file_rdata;
  logic [EQIA_PROG_W-1:0] prog_rdata;
  logic                   file_we;
  logic                   prog_we;

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[b*8 +: 8] = {8{s_q.w_strb[b]}};
  end

  // the store address follows whichever pointer the running op uses
  always_comb begin
    file_addr = (s_q.op == EQIA_OP_FILE_WR) ? s_q.file_wr_ptr : s_q.file_rd_ptr;
    prog_addr = (s_q.op == EQIA_OP_PROG_WR) ? s_q.prog_wr_ptr : s_q.prog_rd_ptr;
    file_we   = (s_q.op == EQIA_OP_FILE_WR) && (s_q.phase == 2'd0);
    prog_we   = (s_q.op == EQIA_OP_PROG_WR) && (s_q.phase == 2'd0);
  end

  eqia_file #(
    .DEPTH (EQIA_FILE_DEPTH)
  ) u_file (
    .clk     (clk),
    .nrst    (nrst),
    .wr_en   (file_we),
    .addr    (file_addr),
    .wdata   (s_q.stage[EQIA_FILE_W-1:0]),
    .live_in (live_in),
    .rdata   (file_rdata)
  );

  eqia_prog #(
    .DEPTH (EQIA_PROG_DEPTH)
  ) u_prog (
    .clk   (clk),
    .nrst  (nrst),
    .wr_en (prog_we),
    .addr  (prog_addr),
    .wdata (s_q.stage),
    .rdata (prog_rdata)
  );

  always_comb begin
    wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    rd_fire = s_axi_arvalid && !s_q.rvalid;
    map_ok  = 1'b0;
    rd_word = '0;
    case (s_axi_araddr[EQIA_ADDR_W-1:EQIA_IDX_LSB])
      EQIA_OFS_FILE_RD: begin
        rd_word = {26'h0, s_q.file_rd_ptr};
        map_ok  = 1'b1;
      end
      EQIA_OFS_FILE_WR: begin
        rd_word = {26'h0, s_q.file_wr_ptr};
        map_ok  = 1'b1;
      end
      EQIA_OFS_PROG_RD: begin
        rd_word = {26'h0, s_q.prog_rd_ptr};
        map_ok  = 1'b1;
      end
      EQIA_OFS_PROG_WR: begin
        rd_word = {26'h0, s_q.prog_wr_ptr};
        map_ok  = 1'b1;
      end
      EQIA_OFS_STAGE: begin
        rd_word = s_q.stage;
        map_ok  = 1'b1;
      end
      default: begin
        rd_word = '0;
        map_ok  = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    // write address and data are captured independently
    if (s_axi_awvalid && !s_q.aw_hold) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr[EQIA_ADDR_W-1:EQIA_IDX_LSB];
    end
    if (s_axi_wvalid && !s_q.w_hold) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // transfer sequencer: phase 0 issues, 1 waits on ram, 2 captures
    if (s_q.op != 4'b0000) begin
      s_d.phase = 2'(s_q.phase + 2'd1);
      if (s_q.phase == 2'd2) begin
        if (s_q.op == EQIA_OP_FILE_RD) begin
          s_d.stage = {16'h0, file_rdata};
        end else if (s_q.op == EQIA_OP_PROG_RD) begin
          s_d.stage = prog_rdata;
        end
        s_d.op    = 4'b0000;
        s_d.phase = 2'd0;
      end
    end

    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = EQIA_RESP_OKAY;
      case (s_q.aw_addr)
        EQIA_OFS_FILE_RD: begin
          if (s_q.w_strb[0]) begin
            s_d.file_rd_ptr = s_q.w_data[5:0];
            s_d.op          = EQIA_OP_FILE_RD;
            s_d.phase       = 2'd0;
          end
        end
        EQIA_OFS_FILE_WR: begin
          if (s_q.w_strb[0]) begin
            s_d.file_wr_ptr = s_q.w_data[5:0];
            s_d.op          = EQIA_OP_FILE_WR;
            s_d.phase       = 2'd0;
          end
        end
        EQIA_OFS_PROG_RD: begin
          if (s_q.w_strb[0]) begin
            s_d.prog_rd_ptr = s_q.w_data[5:0];
            s_d.op          = EQIA_OP_PROG_RD;
            s_d.phase       = 2'd0;
          end
        end
        EQIA_OFS_PROG_WR: begin
          if (s_q.w_strb[0]) begin
            s_d.prog_wr_ptr = s_q.w_data[5:0];
            s_d.op          = EQIA_OP_PROG_WR;
            s_d.phase       = 2'd0;
          end
        end
        EQIA_OFS_STAGE: begin
          s_d.stage = (s_q.stage & ~wmask) | (s_q.w_data & wmask);
        end
        default: begin
          s_d.bresp = EQIA_RESP_SLVERR;
        end
      endcase
    end

    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = map_ok ? EQIA_RESP_OKAY : EQIA_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q             <= '0;
      s_q.stage       <= EQIA_STAGE_RST;
      s_q.file_rd_ptr <= EQIA_PTR_RST;
      s_q.file_wr_ptr <= EQIA_PTR_RST;
      s_q.prog_rd_ptr <= EQIA_PTR_RST;
      s_q.prog_wr_ptr <= EQIA_PTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    s_axi_awready = !s_q.aw_hold;
    s_axi_wready  = !s_q.w_hold;
    s_axi_bvalid  = s_q.bvalid;
    s_axi_bresp   = s_q.bresp;
    s_axi_arready = !s_q.rvalid;
    s_axi_rvalid  = s_q.rvalid;
    s_axi_rdata   = s_q.rdata;
    s_axi_rresp   = s_q.rresp;
    xfer_busy     = (s_q.op != 4'b0000);
  end
endmodule : eqia_top

// ### eqia_checker.sv
// assertion checker for the equalizer indirect access port
`timescale 1ns/100ps
module eqia_checker
  import eqia_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        xfer_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer not held");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer not held");
  property p_arrv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_arrv: assert property (p_arrv) else $error("read answer late");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("second read accepted");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_blen; $rose(xfer_busy) |-> xfer_busy [*3] ##1 !xfer_busy; endproperty
  a_blen: assert property (p_blen) else $error("transfer length wrong");
  property p_bcause; $rose(xfer_busy) |-> $rose(s_axi_bvalid); endproperty
  a_bcause: assert property (p_bcause) else $error("transfer without write");
  c_xfer: cover property ($rose(xfer_busy));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == EQIA_RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : eqia_checker
bind eqia_top eqia_checker u_eqia_checker (.clk, .nrst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .xfer_busy);

// ### tb_top.sv
// self-checking bench for the equalizer indirect access block
`timescale 1ns/100ps
module tb_top;
  import eqia_pkg::*;
  logic        clk, nrst, awv, awr, wv, wrd, bv, bp, arv, arr, rv, rp, busy;
  logic [1:0]  br, rr;
  logic [EQIA_ADDR_W-1:0] awa, ara;
  logic [3:0]  ws;
  logic [31:0] wd, rdt;
  logic [111:0] live;
  int          bad_count, cmp_count;

  eqia_top u_eqia_top (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bp), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rp), .live_in(live), .xfer_busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic hung;
    bad_count++;
    $display("Error handshake expected answer seen none");
    wrap_up();
  endtask : hung

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic ta, tw, tb;
    n = 0;
    awa <= {a, 2'b00};
    wd  <= d;
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    bp  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      r  = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
    end while (!tb && n < 64);
    bp <= 1'b0;
    if (!tb) hung();
    // let the indirect transfer finish before the next access
    repeat (4) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta, tb;
    n = 0;
    ara <= {a, 2'b00};
    arv <= 1'b1;
    rp  <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tb = rv;
      d  = rdt;
      r  = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      n++;
    end while (!tb && n < 64);
    rp <= 1'b0;
    if (!tb) hung();
    @(posedge clk);
  endtask : rd

  task automatic w32(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk("bresp", {30'h0, EQIA_RESP_OKAY}, {30'h0, r});
  endtask : w32

  task automatic r32(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rresp", {30'h0, EQIA_RESP_OKAY}, {30'h0, r});
    chk($sformatf("read %h", a), e, d);
  endtask : r32

  task automatic t_reset;
    for (int i = 0; i < 5; i++) r32(EQIA_OFS_FILE_RD + 8'(i), 32'h0);
  endtask : t_reset

  task automatic t_ptr;
    for (int i = 0; i < 4; i++) begin
      w32(EQIA_OFS_FILE_RD + 8'(i), 32'hffff_ffff);
      r32(EQIA_OFS_FILE_RD + 8'(i), 32'h0000_003f);
    end
  endtask : t_ptr

  task automatic t_file;
    for (int i = 0; i < 2; i++) begin
      w32(EQIA_OFS_STAGE, 32'hdead_1230 + 32'(i));
      w32(EQIA_OFS_FILE_WR, {26'h0, 6'(i * 47)});
      r32(EQIA_OFS_STAGE, 32'hdead_1230 + 32'(i));
    end
    for (int i = 0; i < 2; i++) begin
      w32(EQIA_OFS_STAGE, 32'hffff_0000);
      w32(EQIA_OFS_FILE_RD, {26'h0, 6'(i * 47)});
      r32(EQIA_OFS_STAGE, 32'h0000_1230 + 32'(i));
      w32(EQIA_OFS_FILE_RD, {26'h0, 6'(i * 47)});
      r32(EQIA_OFS_STAGE, 32'h0000_1230 + 32'(i));
    end
  endtask : t_file

  task automatic t_live;
    for (int k = 0; k < EQIA_LIVE_N; k++) begin
      w32(EQIA_OFS_FILE_RD, 32'd28 + 32'(k));
      r32(EQIA_OFS_STAGE, 32'h0000_5a00 + 32'(k));
    end
  endtask : t_live

  task automatic t_prog;
    for (int i = 0; i < 2; i++) begin
      w32(EQIA_OFS_STAGE, 32'h8765_4321 ^ 32'(i));
      w32(EQIA_OFS_PROG_WR, {26'h0, 6'(i * 63)});
      r32(EQIA_OFS_STAGE, 32'h8765_4321 ^ 32'(i));
    end
    for (int i = 0; i < 2; i++) begin
      w32(EQIA_OFS_STAGE, 32'h0);
      w32(EQIA_OFS_PROG_RD, {26'h0, 6'(i * 63)});
      r32(EQIA_OFS_STAGE, 32'h8765_4321 ^ 32'(i));
    end
  endtask : t_prog

  task automatic t_err;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h40, 32'h1, 4'hf, r);
    chk("bresp", {30'h0, EQIA_RESP_SLVERR}, {30'h0, r});
    rd(8'h40, d, r);
    chk("rresp", {30'h0, EQIA_RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    w32(EQIA_OFS_STAGE, 32'h0);
    wr(EQIA_OFS_STAGE, 32'hffff_ffff, 4'h1, r);
    r32(EQIA_OFS_STAGE, 32'h0000_00ff);
  endtask : t_err

  initial begin
    nrst = 1'b0;
    {awv, wv, bp, arv, rp, awa, ara, ws, wd} = '0;
    for (int k = 0; k < EQIA_LIVE_N; k++) live[16*k +: 16] = 16'h5a00 + 16'(k);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ptr();
    t_file();
    t_live();
    t_prog();
    t_err();
    wrap_up();
  end
endmodule : tb_top
